// ===== hpp_addr_latch.sv
// Address latch with transparent and hold phases
`timescale 1ns/1ps
module hpp_addr_latch #(
	parameter int ADDR_W = 8
) (
	input  wire logic              sys_clk_in,
	input  wire logic              rst_n_in,
	input  wire logic              ale_in,
	input  wire logic [ADDR_W-1:0] addr_in,
	output logic      [ADDR_W-1:0] addr_out
);
	typedef struct packed
	{
		logic [ADDR_W-1:0] held;
	} hpp_al_s;

	hpp_al_s st_q;
	hpp_al_s st_d;

	if (ADDR_W < 2)
	begin : g_chk
		$error("Address width too small");
	end

	always_comb
	begin
		st_d = st_q;
		if (ale_in)
		begin
			st_d.held = addr_in;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			st_q <= '0;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	// Transparent while high, held value after the fall
	assign addr_out = ale_in ? addr_in : st_q.held;
endmodule : hpp_addr_latch

// ===== hpp_host_model.sv
// Host processor model for the parallel port
`timescale 1ns/1ps
module hpp_host_model (
	input  wire logic        clk_in,
	output logic             cs_n_out,
	output logic             ale_out,
	output logic [7:0]       a_out,
	output logic             wr_n_out,
	output logic             rd_n_out,
	output logic [15:0]      d_out,
	input  wire logic [15:0] d_in
);
	// ****
	// Bus cycles
	// ****
	initial
	begin
		cs_n_out = 1'h1;
		ale_out  = 1'h1;
		a_out    = 8'h00;
		wr_n_out = 1'h1;
		rd_n_out = 1'h1;
		d_out    = 16'h0000;
	end
	task automatic go();
		@(posedge clk_in);
		#1;
	endtask : go
	task automatic latch(input logic [7:0] a, input logic lv);
		go();
		a_out   = a;
		ale_out = lv;
	endtask : latch
	task automatic wr(input logic st, input logic cs, input logic [7:0] a, input logic [15:0] d);
		go();
		cs_n_out = cs;
		a_out    = a;
		d_out    = d;
		wr_n_out = 1'h0;
		rd_n_out = !st;
		go();
		rd_n_out = 1'h1;
		go();
		cs_n_out = 1'h1;
		wr_n_out = 1'h1;
		rd_n_out = 1'h1;
		d_out    = ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		go();
		cs_n_out = 1'h0;
		a_out    = a;
		rd_n_out = 1'h0;
		go();
		go();
		d        = d_in;
		cs_n_out = 1'h1;
		rd_n_out = 1'h1;
	endtask : rd
endmodule : hpp_host_model

// ===== hpp_host_port.sv
// Parallel host port: strobe decode, register file, data pins
`timescale 1ns/1ps
module hpp_host_port #(
	parameter int SRC_N = 16
) (
	input  wire logic                       sys_clk_in,
	input  wire logic                       rstn_in,
	input  wire logic                       bus_width_select_in,
	input  wire logic                       bus_style_select_in,
	input  wire logic                       chip_select_n_in,
	input  wire logic                       address_latch_enable_in,
	input  wire logic [hpp_pkg::ADDR_W-1:0] host_address_lines_in,
	input  wire logic                       write_strobe_n_in,
	input  wire logic                       read_strobe_n_in,
	input  wire logic [hpp_pkg::DATA_W-1:0] host_data_lines_in,
	output logic      [hpp_pkg::DATA_W-1:0] host_data_lines_out,
	output logic                            host_data_lines_oe_out,
	input  wire logic [SRC_N-1:0]           irq_src_in,
	input  wire logic [SRC_N-1:0]           irq_mask_in,
	output logic                            host_interrupt_n_out,
	output logic                            host_interrupt_n_oe_out,
	output logic [hpp_pkg::DATA_W*hpp_pkg::WORD_N-1:0] regs_out
);
	localparam int DW = hpp_pkg::DATA_W;
	localparam int HW = hpp_pkg::HALF_W;
	localparam int WN = hpp_pkg::WORD_N;
	localparam int IW = hpp_pkg::ADDR_W - 1;

	// ********************
	// Parameter checks
	// ********************
	if (SRC_N < 1 || DW != 2 * HW || WN != 2 ** IW)
	begin : g_chk
		$error("Unsupported port geometry");
	end

	// ********************
	// Reset release
	// ********************
	logic [1:0] rst_sync_q;
	logic       rst_n;

	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			rst_sync_q <= 2'h0;
		end
		else
		begin
			rst_sync_q <= {rst_sync_q[0], 1'h1};
		end
	end

	assign rst_n = rst_sync_q[1];

	// ********************
	// Address latch
	// ********************
	logic [hpp_pkg::ADDR_W-1:0] addr;

	hpp_addr_latch #(
		.ADDR_W (hpp_pkg::ADDR_W)
	) u_latch (
		.sys_clk_in (sys_clk_in),
		.rst_n_in   (rst_n),
		.ale_in     (address_latch_enable_in),
		.addr_in    (host_address_lines_in),
		.addr_out   (addr)
	);

	property p_latch_open;
		@(posedge sys_clk_in) disable iff (!rst_n)
			address_latch_enable_in |-> (addr == host_address_lines_in);
	endproperty
	a_latch_open: assert property (p_latch_open) else $error("Latch not transparent");

	property p_latch_fall;
		@(posedge sys_clk_in) disable iff (!rst_n)
			$fell(address_latch_enable_in) |-> (addr == $past(host_address_lines_in));
	endproperty
	a_latch_fall: assert property (p_latch_fall) else $error("Address not captured on fall");

	property p_latch_hold;
		@(posedge sys_clk_in) disable iff (!rst_n)
			(!address_latch_enable_in && !$past(address_latch_enable_in)) |-> $stable(addr);
	endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("Held address moved");

	// ********************
	// Interrupt
	// ********************
	logic irq_oe;

	hpp_irq_gate #(
		.SRC_N (SRC_N)
	) u_irq (
		.sys_clk_in   (sys_clk_in),
		.rst_n_in     (rst_n),
		.src_in       (irq_src_in),
		.mask_in      (irq_mask_in),
		.irq_n_oe_out (irq_oe)
	);

	assign host_interrupt_n_oe_out = irq_oe;
	assign host_interrupt_n_out    = 1'h0;

	property p_irq_hold;
		@(posedge sys_clk_in) disable iff (!rst_n)
			(host_interrupt_n_oe_out && |(irq_src_in & ~irq_mask_in)) |=> host_interrupt_n_oe_out;
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("Interrupt released early");

	// ********************
	// Strobe decode
	// ********************
	typedef struct packed
	{
		logic [WN-1:0][DW-1:0] regs;
		logic [DW-1:0]         rdata;
		logic                  oe;
		logic                  ds_q;
		hpp_pkg::hpp_phase_e   phase;
	} hpp_st_s;

	hpp_st_s st_q;
	hpp_st_s st_d;

	logic          sel;
	logic          is8;
	logic          rd_act;
	logic          wr_lvl;
	logic          ds_rise;
	logic [IW-1:0] widx;
	logic          bsel;
	logic [DW-1:0] rword;
	logic [DW-1:0] wdat;

	assign sel  = !chip_select_n_in;
	assign is8  = (bus_width_select_in == hpp_pkg::WIDTH_8);
	assign widx = addr[hpp_pkg::ADDR_W-1:1];
	assign bsel = addr[hpp_pkg::BYTE_LSB];
	assign wdat = is8 ? {{HW{1'h0}}, host_data_lines_in[HW-1:0]} : host_data_lines_in;

	always_comb
	begin
		if (bus_style_select_in == hpp_pkg::STYLE_SEP)
		begin
			rd_act  = sel && !read_strobe_n_in;
			wr_lvl  = sel && !write_strobe_n_in;
			ds_rise = 1'h0;
		end
		else
		begin
			rd_act  = sel && !read_strobe_n_in && write_strobe_n_in;
			wr_lvl  = 1'h0;
			ds_rise = sel && !write_strobe_n_in && !read_strobe_n_in == 1'h0 && st_q.ds_q == 1'h0;
		end
	end

	assign rword = st_q.regs[widx];

	always_comb
	begin
		st_d       = st_q;
		st_d.ds_q  = read_strobe_n_in;
		st_d.phase = hpp_pkg::HPP_IDLE;
		if (rd_act)
		begin
			st_d.phase = hpp_pkg::HPP_READ;
			st_d.oe    = 1'h1;
			if (is8)
			begin
				st_d.rdata = {{HW{1'h0}}, bsel ? rword[DW-1:HW] : rword[HW-1:0]};
			end
			else
			begin
				st_d.rdata = rword;
			end
		end
		else
		begin
			st_d.oe = 1'h0;
		end
		if (wr_lvl || ds_rise)
		begin
			st_d.phase = hpp_pkg::HPP_WRITE;
			if (is8)
			begin
				if (bsel)
				begin
					st_d.regs[widx][DW-1:HW] = wdat[HW-1:0];
				end
				else
				begin
					st_d.regs[widx][HW-1:0] = wdat[HW-1:0];
				end
			end
			else
			begin
				st_d.regs[widx] = wdat;
			end
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_q      <= '0;
			st_q.ds_q <= 1'h1;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	assign host_data_lines_out    = st_q.rdata;
	assign host_data_lines_oe_out = st_q.oe;
	assign regs_out               = st_q.regs;

	// ********************
	// Checks
	// ********************
	property p_release;
		@(posedge sys_clk_in) disable iff (!rst_n) chip_select_n_in |=> !host_data_lines_oe_out;
	endproperty
	a_release: assert property (p_release) else $error("Data driven without select");

	property p_read_drive;
		@(posedge sys_clk_in) disable iff (!rst_n) rd_act |=> host_data_lines_oe_out;
	endproperty
	a_read_drive: assert property (p_read_drive) else $error("Read not driven");

	property p_write_store;
		@(posedge sys_clk_in) disable iff (!rst_n)
			(wr_lvl && !is8) |=> (st_q.regs[$past(widx)] == $past(wdat));
	endproperty
	a_write_store: assert property (p_write_store) else $error("Write lost");

	property p_irq;
		@(posedge sys_clk_in) disable iff (!rst_n) |(irq_src_in & ~irq_mask_in) |=> host_interrupt_n_oe_out;
	endproperty
	a_irq: assert property (p_irq) else $error("Interrupt not asserted");

	property p_irq_off;
		@(posedge sys_clk_in) disable iff (!rst_n) !(|(irq_src_in & ~irq_mask_in)) |=> !host_interrupt_n_oe_out;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("Interrupt stuck");

	property p_no_drive_write;
		@(posedge sys_clk_in) disable iff (!rst_n) (wr_lvl && !rd_act) |=> !host_data_lines_oe_out;
	endproperty
	a_no_drive_write: assert property (p_no_drive_write) else $error("Drive during write");

	property p_upper_zero;
		@(posedge sys_clk_in) disable iff (!rst_n) (rd_act && is8) |=> host_data_lines_out[DW-1:HW] == '0;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("Upper byte in narrow mode");

	property p_ds_write;
		@(posedge sys_clk_in) disable iff (!rst_n) ds_rise |=> st_q.phase == hpp_pkg::HPP_WRITE;
	endproperty
	a_ds_write: assert property (p_ds_write) else $error("Strobe write missed");

	property p_cs_refuse;
		@(posedge sys_clk_in) disable iff (!rst_n)
			chip_select_n_in |=> (st_q.regs == $past(st_q.regs));
	endproperty
	a_cs_refuse: assert property (p_cs_refuse) else $error("Write without select");

	property p_idle_release;
		@(posedge sys_clk_in) disable iff (!rst_n)
			!rd_act |=> !host_data_lines_oe_out;
	endproperty
	a_idle_release: assert property (p_idle_release) else $error("Data driven outside read");

	property p_read_word;
		@(posedge sys_clk_in) disable iff (!rst_n)
			(rd_act && !is8) |=> (host_data_lines_out == $past(rword));
	endproperty
	a_read_word: assert property (p_read_word) else $error("Wrong word read");

	property p_read_byte;
		@(posedge sys_clk_in) disable iff (!rst_n)
			(rd_act && is8) |=> (host_data_lines_out[HW-1:0] ==
				($past(bsel) ? $past(rword[DW-1:HW]) : $past(rword[HW-1:0])));
	endproperty
	a_read_byte: assert property (p_read_byte) else $error("Wrong byte read");

	property p_byte_high;
		@(posedge sys_clk_in) disable iff (!rst_n)
			(wr_lvl && is8 && bsel) |=> (st_q.regs[$past(widx)][DW-1:HW] == $past(host_data_lines_in[HW-1:0]));
	endproperty
	a_byte_high: assert property (p_byte_high) else $error("Upper byte write lost");

	property p_byte_keep;
		@(posedge sys_clk_in) disable iff (!rst_n)
			(wr_lvl && is8 && !bsel) |=> (st_q.regs[$past(widx)][DW-1:HW] == $past(rword[DW-1:HW]));
	endproperty
	a_byte_keep: assert property (p_byte_keep) else $error("Upper byte lost on low byte write");

	property p_ds_data;
		@(posedge sys_clk_in) disable iff (!rst_n)
			(ds_rise && !is8) |=> (st_q.regs[$past(widx)] == $past(wdat));
	endproperty
	a_ds_data: assert property (p_ds_data) else $error("Strobe write data lost");

	property p_ds_dir;
		@(posedge sys_clk_in) disable iff (!rst_n)
			(bus_style_select_in == hpp_pkg::STYLE_DS && !write_strobe_n_in) |-> !rd_act;
	endproperty
	a_ds_dir: assert property (p_ds_dir) else $error("Read in write direction");

	property p_sep_no_rise;
		@(posedge sys_clk_in) disable iff (!rst_n)
			(bus_style_select_in == hpp_pkg::STYLE_SEP) |-> !ds_rise;
	endproperty
	a_sep_no_rise: assert property (p_sep_no_rise) else $error("Strobe edge in separate style");

	property p_ds_level;
		@(posedge sys_clk_in) disable iff (!rst_n)
			(bus_style_select_in == hpp_pkg::STYLE_DS) |-> !wr_lvl;
	endproperty
	a_ds_level: assert property (p_ds_level) else $error("Level write in strobe style");

	property p_sep_write;
		@(posedge sys_clk_in) disable iff (!rst_n)
			(bus_style_select_in == hpp_pkg::STYLE_SEP && sel && !write_strobe_n_in) |=>
				(st_q.phase == hpp_pkg::HPP_WRITE);
	endproperty
	a_sep_write: assert property (p_sep_write) else $error("Write strobe ignored");

	property p_narrow_in;
		@(posedge sys_clk_in) disable iff (!rst_n)
			is8 |-> (wdat[DW-1:HW] == '0);
	endproperty
	a_narrow_in: assert property (p_narrow_in) else $error("Upper lines used in narrow mode");

	property p_phase_idle;
		@(posedge sys_clk_in) disable iff (!rst_n)
			!(rd_act || wr_lvl || ds_rise) |=> (st_q.phase == hpp_pkg::HPP_IDLE);
	endproperty
	a_phase_idle: assert property (p_phase_idle) else $error("Transfer without strobe");
endmodule : hpp_host_port

// ===== hpp_irq_gate.sv
// Interrupt combiner for the open-drain request pin
`timescale 1ns/1ps
module hpp_irq_gate #(
	parameter int SRC_N = 16
) (
	input  wire logic             sys_clk_in,
	input  wire logic             rst_n_in,
	input  wire logic [SRC_N-1:0] src_in,
	input  wire logic [SRC_N-1:0] mask_in,
	output logic                  irq_n_oe_out
);
	typedef struct packed
	{
		logic drive;
	} hpp_ig_s;

	hpp_ig_s st_q;
	hpp_ig_s st_d;

	if (SRC_N < 1)
	begin : g_chk
		$error("Need at least one source");
	end

	always_comb
	begin
		st_d       = st_q;
		st_d.drive = |(src_in & ~mask_in);
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			st_q <= '0;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	assign irq_n_oe_out = st_q.drive;
endmodule : hpp_irq_gate

// ===== hpp_pkg.sv
// Constants and types for the parallel host port
// What this block does
// - Width select low sixteen bit, high eight bit
// - Style select: zero separate strobes, one data strobe
// - Drive data only during reads, else released
// - Eight bit mode ignores upper data lines
// - Sixteen bit mode ignores lowest address line
// - Eight bit mode: lowest address line is LSB
// - Address lines select internal register
// - Separate style: write strobe captures data
// - Data strobe style: write strobe line gives direction
// - Separate style: read strobe drives register contents
// - Data strobe style: write on strobe rising edge
// - Interrupt low while unmasked source active
// - Interrupt stays low until serviced or masked
// - Transfers accepted only with chip select low
// - Latch enable high: address passes through
// - Latch enable fall: address sampled, held
package hpp_pkg;
	localparam int          DATA_W    = 16;
	localparam int          ADDR_W    = 8;
	localparam int          WORD_N    = 128;
	localparam logic        WIDTH_16  = 1'h0;
	localparam logic        WIDTH_8   = 1'h1;
	localparam logic        STYLE_SEP = 1'h0;
	localparam logic        STYLE_DS  = 1'h1;
	localparam logic [15:0] REG_RST   = 16'h0000;
	localparam int          BYTE_LSB  = 0;
	localparam int          HALF_W    = 8;

	typedef enum logic [1:0]
	{
		HPP_IDLE  = 2'h0,
		HPP_READ  = 2'h1,
		HPP_WRITE = 2'h2
	} hpp_phase_e;
endpackage : hpp_pkg

// ===== tb_top.sv
// Self-checking bench for the parallel host port
`timescale 1ns/1ps
`define CHK(a, b) check_count++; if ((a) !== (b)) begin fails++; $display("CHECK FAILED %0t mismatch", $time); end
module tb_top;
	logic          clk  = 1'h0;
	logic          rstn = 1'h0;
	logic          w8   = 1'h0;
	logic          st   = 1'h0;
	logic [15:0]   src  = 16'h0000;
	logic [15:0]   msk  = 16'h0000;
	logic          cs_n, ale, wr_n, rd_n, doe, ioe, inn;
	logic [7:0]    a;
	logic [15:0]   hd, dout, bus, rv;
	logic [2047:0] regs;
	int            fails = 0;
	int            check_count = 0;
	// ****
	// Harness
	// ****
	assign bus = doe ? dout : {w8 ? 8'h00 : hd[15:8], hd[7:0]};
	initial
	begin
		forever #12.5 clk = ~clk;
	end
	hpp_host_model hm (.clk_in(clk), .cs_n_out(cs_n), .ale_out(ale), .a_out(a), .wr_n_out(wr_n),
		.rd_n_out(rd_n), .d_out(hd), .d_in(bus));
	hpp_host_port DUT (.sys_clk_in(clk), .rstn_in(rstn), .bus_width_select_in(w8), .bus_style_select_in(st),
		.chip_select_n_in(cs_n), .address_latch_enable_in(ale), .host_address_lines_in(a),
		.write_strobe_n_in(wr_n), .read_strobe_n_in(rd_n), .host_data_lines_in(bus),
		.host_data_lines_out(dout), .host_data_lines_oe_out(doe), .irq_src_in(src), .irq_mask_in(msk),
		.host_interrupt_n_out(inn), .host_interrupt_n_oe_out(ioe), .regs_out(regs));
	// ****
	// Scenarios
	// ****
	task automatic t_wide();
		hm.wr(0, 0, 8'h10, 16'hbeef);
		hm.wr(0, 0, 8'h12, 16'h1234);
		hm.go();
		`CHK(regs[16*8 +: 16], 16'hbeef)
		`CHK(regs[16*9 +: 16], 16'h1234)
		hm.rd(8'h10, rv);
		`CHK(rv, 16'hbeef)
		hm.go();
		hm.go();
		`CHK(doe, 1'h0)
		hm.wr(0, 1, 8'h10, 16'h5555);
		hm.go();
		`CHK(regs[16*8 +: 16], 16'hbeef)
		`CHK(doe, 1'h0)
		$display("test wide done");
	endtask : t_wide
	task automatic t_byte();
		w8 = 1'h1;
		hm.wr(0, 0, 8'h05, 16'h00a5);
		hm.wr(0, 0, 8'h04, 16'h003c);
		hm.go();
		`CHK(regs[16*2 +: 16], 16'ha53c)
		hm.rd(8'h05, rv);
		`CHK(rv[7:0], 8'ha5)
		`CHK(rv[15:8], 8'h00)
		w8 = 1'h0;
		$display("test byte done");
	endtask : t_byte
	task automatic t_ds();
		st = 1'h1;
		hm.wr(1, 0, 8'h20, 16'hc0de);
		hm.go();
		`CHK(regs[16*16 +: 16], 16'hc0de)
		hm.rd(8'h20, rv);
		`CHK(rv, 16'hc0de)
		st = 1'h0;
		$display("test strobe done");
	endtask : t_ds
	task automatic t_ale();
		hm.latch(8'h30, 1'h1);
		hm.latch(8'h30, 1'h0);
		hm.wr(0, 0, 8'h77, 16'h6677);
		hm.go();
		`CHK(regs[16*24 +: 16], 16'h6677)
		`CHK(regs[16*59 +: 16], 16'h0000)
		hm.latch(8'h00, 1'h1);
		$display("test latch done");
	endtask : t_ale
	task automatic t_irq();
		src = 16'h0010;
		repeat (3) hm.go();
		`CHK(ioe, 1'h1)
		`CHK(inn, 1'h0)
		msk = 16'h0010;
		repeat (3) hm.go();
		`CHK(ioe, 1'h0)
		$display("test irq done");
	endtask : t_irq
	// ****
	// Sequence
	// ****
	initial
	begin
		repeat (4) @(posedge clk);
		#1;
		`CHK(doe, 1'h0)
		rstn = 1'h1;
		repeat (3) @(posedge clk);
		t_wide();
		t_byte();
		t_ds();
		t_ale();
		t_irq();
		print_verdict();
	end
	initial
	begin
		#100000;
		fails++;
		print_verdict();
	end
	task automatic print_verdict();
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : print_verdict
endmodule : tb_top
